// ---- core/scb_pkg.sv ----
// constants and types shared by both ends of the 4-bit counter link
package scb_pkg;

  // ****************************************************************
  // counter geometry
  // ****************************************************************
  localparam int         COUNT_W    = 4;
  localparam logic [3:0] COUNT_MAX  = 4'hf;
  localparam logic [3:0] COUNT_ZERO = 4'h0;
  localparam logic [3:0] COUNT_ONE  = 4'h1;
  localparam logic [3:0] COUNT_RST  = 4'h0;

  // ****************************************************************
  // event tallies
  // ****************************************************************
  localparam int          EVT_W   = 16;
  localparam logic [15:0] EVT_RST = 16'h0000;
  localparam logic [15:0] EVT_ONE = 16'h0001;

  // ****************************************************************
  // operating modes, in rising priority
  // ****************************************************************
  typedef enum logic [1:0] {
    SCB_MODE_HOLD  = 2'b00,
    SCB_MODE_COUNT = 2'b01,
    SCB_MODE_LOAD  = 2'b10,
    SCB_MODE_CLEAR = 2'b11
  } scb_mode_t;

  // ****************************************************************
  // controller register port
  // ****************************************************************
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 32;
  localparam logic [7:0]  REG_CTRL    = 8'h00;
  localparam logic [7:0]  REG_PRESET  = 8'h04;
  localparam logic [7:0]  REG_CMD     = 8'h08;
  localparam logic [7:0]  REG_MODULUS = 8'h0c;
  localparam logic [7:0]  REG_STATUS  = 8'h10;
  localparam logic [7:0]  REG_CARRIES = 8'h14;
  localparam logic [31:0] RDATA_ZERO  = 32'h0000_0000;

  // ctrl fields
  localparam int         CTRL_W          = 4;
  localparam int         CTRL_PAR_BIT    = 0;
  localparam int         CTRL_TRK_BIT    = 1;
  localparam int         CTRL_MOD_BIT    = 2;
  localparam int         CTRL_HOLDCLR_BIT = 3;
  localparam logic [3:0] CTRL_RST        = 4'h0;

  // command fields, write only
  localparam int CMD_LOAD_BIT  = 0;
  localparam int CMD_CLEAR_BIT = 1;

  // status fields
  localparam int STATUS_CARRY_BIT = 4;
  localparam int STATUS_MODE_LSB  = 8;

  localparam logic [3:0] PRESET_RST  = 4'h0;
  localparam logic [3:0] MODULUS_RST = 4'hf;

endpackage

// ---- core/scb_link_if.sv ----
// pin-level link between the counter and its driving logic
`timescale 1ns/1ps
`default_nettype none

interface scb_link_if;
  import scb_pkg::*;

  logic                 sync_zero_request_n;
  logic                 load_n;
  logic                 count_enable_parallel;
  logic                 count_enable_trickle;
  logic [COUNT_W-1:0]   preset_data;
  logic [COUNT_W-1:0]   count;
  logic                 ripple_carry_out;

  modport dev (
    input  sync_zero_request_n,
    input  load_n,
    input  count_enable_parallel,
    input  count_enable_trickle,
    input  preset_data,
    output count,
    output ripple_carry_out
  );

  modport ctl (
    output sync_zero_request_n,
    output load_n,
    output count_enable_parallel,
    output count_enable_trickle,
    output preset_data,
    input  count,
    input  ripple_carry_out
  );

endinterface

`default_nettype wire

// ---- core/scb_counter_dev.sv ----
// synchronous presettable 4-bit binary counter with event tallies
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// event tally, one per kind of edge
// ****************************************************************
module scb_evt_cnt
  import scb_pkg::*;
#(
  parameter int W = EVT_W
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         srst,
  // event in
  input  wire logic         hit,
  // running total
  output logic [W-1:0]      total
);

  wire [W-1:0] next_total;

  assign next_total = total + W'(1);

  always_ff @(posedge clk) begin
    if (srst) begin
      total <= '0;
    end else if (hit) begin
      total <= next_total;
    end
  end

endmodule

module scb_counter_dev
  import scb_pkg::*;
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               srst,
  // link to driving logic
  scb_link_if.dev                 link,
  // local observation
  output logic [COUNT_W-1:0]      count_mirror,
  output scb_mode_t               mode_seen,
  output logic                    wrap_pulse,
  output logic [EVT_W-1:0]        inc_total,
  output logic [EVT_W-1:0]        load_total,
  output logic [EVT_W-1:0]        clear_total
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic [COUNT_W-1:0] count;
  logic [COUNT_W-1:0] next_count;
  scb_mode_t          mode_now;

  // ****************************************************************
  // control decode
  // ****************************************************************
  wire clear_act;
  wire load_act;
  wire count_act;
  wire at_max;
  wire is_count;
  wire is_load;
  wire is_clear;

  assign clear_act = ~link.sync_zero_request_n;
  assign load_act  = ~link.load_n;
  assign count_act = link.count_enable_parallel &
                     link.count_enable_trickle;
  assign at_max    = (count == COUNT_MAX);

  always_comb begin
    if (clear_act) begin
      mode_now = SCB_MODE_CLEAR;
    end else if (load_act) begin
      mode_now = SCB_MODE_LOAD;
    end else if (count_act) begin
      mode_now = SCB_MODE_COUNT;
    end else begin
      mode_now = SCB_MODE_HOLD;
    end
  end

  assign is_count = (mode_now == SCB_MODE_COUNT);
  assign is_load  = (mode_now == SCB_MODE_LOAD);
  assign is_clear = (mode_now == SCB_MODE_CLEAR);

  // ****************************************************************
  // next count
  // ****************************************************************
  always_comb begin
    case (mode_now)
      SCB_MODE_CLEAR: begin
        next_count = COUNT_ZERO;
      end
      SCB_MODE_LOAD: begin
        next_count = link.preset_data;
      end
      SCB_MODE_COUNT: begin
        next_count = at_max ? COUNT_ZERO : count + COUNT_ONE;
      end
      default: begin
        next_count = count;
      end
    endcase
  end

  // ****************************************************************
  // count register
  // ****************************************************************
  // all bits on one edge
  // inputs act only at the edge
  always_ff @(posedge clk) begin
    if (srst) begin
      count <= COUNT_RST;
    end else begin
      count <= next_count;
    end
  end

  assign link.count = count;

  // ****************************************************************
  // ripple carry
  // ****************************************************************
  // terminal count gated by trickle
  // ready to drive next stage enables
  assign link.ripple_carry_out = at_max & link.count_enable_trickle;

  // ****************************************************************
  // local observation
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      count_mirror <= COUNT_RST;
      mode_seen    <= SCB_MODE_HOLD;
      wrap_pulse   <= 1'b0;
    end else begin
      count_mirror <= next_count;
      mode_seen    <= mode_now;
      wrap_pulse   <= is_count & at_max;
    end
  end

  // ****************************************************************
  // event tallies
  // ****************************************************************
  scb_evt_cnt #(
    .W     (EVT_W)
  ) u_inc_cnt (
    .clk   (clk),
    .srst  (srst),
    .hit   (is_count),
    .total (inc_total)
  );

  scb_evt_cnt #(
    .W     (EVT_W)
  ) u_load_cnt (
    .clk   (clk),
    .srst  (srst),
    .hit   (is_load),
    .total (load_total)
  );

  scb_evt_cnt #(
    .W     (EVT_W)
  ) u_clear_cnt (
    .clk   (clk),
    .srst  (srst),
    .hit   (is_clear),
    .total (clear_total)
  );

endmodule

`default_nettype wire

// ---- core/scb_counter_ctl.sv ----
// register-driven controller that steers the counter over the link
`timescale 1ns/1ps
`default_nettype none

module scb_counter_ctl
  import scb_pkg::*;
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               srst,
  // register port
  input  wire logic [ADDR_W-1:0]  bus_addr,
  input  wire logic [DATA_W-1:0]  bus_wdata,
  input  wire logic               bus_wr,
  input  wire logic               bus_rd,
  output logic [DATA_W-1:0]       bus_rdata,
  // link to counter
  scb_link_if.ctl                 link
);

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [CTRL_W-1:0]  ctrl;
  logic [COUNT_W-1:0] preset;
  logic [COUNT_W-1:0] modulus;
  logic               load_req;
  logic               clear_req;
  logic [EVT_W-1:0]   carries;
  logic [DATA_W-1:0]  next_rdata;

  // ****************************************************************
  // address decode
  // ****************************************************************
  wire hit_ctrl;
  wire hit_preset;
  wire hit_cmd;
  wire hit_modulus;
  wire hit_status;
  wire hit_carries;
  wire mod_hit;
  wire stage_step;

  assign hit_ctrl    = (bus_addr == REG_CTRL);
  assign hit_preset  = (bus_addr == REG_PRESET);
  assign hit_cmd     = (bus_addr == REG_CMD);
  assign hit_modulus = (bus_addr == REG_MODULUS);
  assign hit_status  = (bus_addr == REG_STATUS);
  assign hit_carries = (bus_addr == REG_CARRIES);

  assign mod_hit = ctrl[CTRL_MOD_BIT] & (link.count == modulus);
  assign link.sync_zero_request_n = ~(clear_req | mod_hit |
                                      ctrl[CTRL_HOLDCLR_BIT]);

  // carry used as synchronous enable only
  assign stage_step = link.ripple_carry_out &
                      link.count_enable_parallel &
                      link.load_n & link.sync_zero_request_n;

  // ****************************************************************
  // writes
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl      <= CTRL_RST;
      preset    <= PRESET_RST;
      modulus   <= MODULUS_RST;
      load_req  <= 1'b0;
      clear_req <= 1'b0;
    end else begin
      load_req  <= bus_wr & hit_cmd & bus_wdata[CMD_LOAD_BIT];
      clear_req <= bus_wr & hit_cmd & bus_wdata[CMD_CLEAR_BIT];
      if (bus_wr & hit_ctrl) begin
        ctrl <= bus_wdata[CTRL_W-1:0];
      end
      if (bus_wr & hit_preset) begin
        preset <= bus_wdata[COUNT_W-1:0];
      end
      if (bus_wr & hit_modulus) begin
        modulus <= bus_wdata[COUNT_W-1:0];
      end
    end
  end

  assign link.count_enable_parallel = ctrl[CTRL_PAR_BIT];
  assign link.count_enable_trickle  = ctrl[CTRL_TRK_BIT];
  assign link.preset_data           = preset;
  assign link.load_n                = ~load_req;

  // ****************************************************************
  // cascaded upper stage
  // ****************************************************************
  // carry drives next stage enable
  always_ff @(posedge clk) begin
    if (srst) begin
      carries <= EVT_RST;
    end else if (stage_step) begin
      carries <= carries + EVT_ONE;
    end
  end

  // ****************************************************************
  // reads
  // ****************************************************************
  always_comb begin
    next_rdata = RDATA_ZERO;
    if (hit_ctrl) begin
      next_rdata[CTRL_W-1:0] = ctrl;
    end else if (hit_preset) begin
      next_rdata[COUNT_W-1:0] = preset;
    end else if (hit_modulus) begin
      next_rdata[COUNT_W-1:0] = modulus;
    end else if (hit_status) begin
      next_rdata[COUNT_W-1:0]      = link.count;
      next_rdata[STATUS_CARRY_BIT] = link.ripple_carry_out;
      next_rdata[STATUS_MODE_LSB]  = link.load_n;
      next_rdata[STATUS_MODE_LSB+1] = link.sync_zero_request_n;
    end else if (hit_carries) begin
      next_rdata[EVT_W-1:0] = carries;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      bus_rdata <= RDATA_ZERO;
    end else if (bus_rd) begin
      bus_rdata <= next_rdata;
    end else begin
      bus_rdata <= RDATA_ZERO;
    end
  end

endmodule

`default_nettype wire

// ---- test/scb_link_chk.sv ----
// assertions on the link between the counter and its controller
`timescale 1ns/1ps
`default_nettype none

module scb_link_chk
  import scb_pkg::*;
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               srst,
  // link signals
  input  wire logic               sync_zero_request_n,
  input  wire logic               load_n,
  input  wire logic               count_enable_parallel,
  input  wire logic               count_enable_trickle,
  input  wire logic [COUNT_W-1:0] preset_data,
  input  wire logic [COUNT_W-1:0] count,
  input  wire logic               ripple_carry_out
);
  // ****************************************************************
  // edge kinds
  // ****************************************************************
  logic srst_q;
  always_ff @(posedge clk) begin
    srst_q <= srst;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst || srst_q);
  sequence s_clear;
    !sync_zero_request_n;
  endsequence
  sequence s_load;
    sync_zero_request_n && !load_n;
  endsequence
  sequence s_inc;
    sync_zero_request_n && load_n && count_enable_parallel &&
      count_enable_trickle;
  endsequence
  a_clear_zero: assert property (
    s_clear |=> count == COUNT_ZERO) else $error("no clear");
  a_clear_over_load: assert property (
    s_clear ##0 !load_n |=> count == COUNT_ZERO) else $error("load won");
  a_load_copy: assert property (
    s_load |=> count == $past(preset_data)) else $error("bad load");
  a_load_over_count: assert property (
    s_load ##0 (count_enable_parallel && count_enable_trickle)
    |=> count == $past(preset_data)) else $error("count won");
  a_count_step: assert property (
    s_inc |=> count == $past(count) + COUNT_ONE) else $error("bad step");
  a_count_wrap: assert property (
    s_inc ##0 count == COUNT_MAX |=> count == COUNT_ZERO)
    else $error("no wrap");
  a_hold_still: assert property (
    sync_zero_request_n && load_n &&
    !(count_enable_parallel && count_enable_trickle) |=> $stable(count))
    else $error("count moved");
  a_carry_gate: assert property (
    ripple_carry_out == (count == COUNT_MAX && count_enable_trickle))
    else $error("bad carry");
endmodule

`default_nettype wire

// ---- test/tb.sv ----
// self-checking bench for the counter and its controller
`timescale 1ns/1ps
`default_nettype none

module tb;
  import scb_pkg::*;
  logic               clk = 1'b0;
  logic               srst = 1'b1;
  logic [ADDR_W-1:0]  bus_addr = 8'h00;
  logic [DATA_W-1:0]  bus_wdata = 32'h0000_0000;
  logic               bus_wr = 1'b0;
  logic               bus_rd = 1'b0;
  logic [DATA_W-1:0]  bus_rdata;
  logic [COUNT_W-1:0] count_mirror;
  scb_mode_t          mode_seen;
  logic               wrap_pulse;
  logic [EVT_W-1:0]   inc_total;
  logic [EVT_W-1:0]   load_total;
  logic [EVT_W-1:0]   clear_total;
  logic               carry_seen;
  int                 errors = 0;
  int                 n_checks = 0;
  logic [3:0]         exp;
  int                 i;

  always #5 clk = ~clk;

  scb_link_if link ();
  scb_counter_dev i_scb_counter_dev (.clk(clk), .srst(srst), .link(link),
    .count_mirror(count_mirror), .mode_seen(mode_seen),
    .wrap_pulse(wrap_pulse), .inc_total(inc_total),
    .load_total(load_total), .clear_total(clear_total));
  assign carry_seen = link.ripple_carry_out;
  scb_counter_ctl i_scb_counter_ctl (.clk(clk), .srst(srst),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .link(link));
  scb_link_chk i_scb_link_chk (.clk(clk), .srst(srst),
    .sync_zero_request_n(link.sync_zero_request_n), .load_n(link.load_n),
    .count_enable_parallel(link.count_enable_parallel),
    .count_enable_trickle(link.count_enable_trickle),
    .preset_data(link.preset_data), .count(link.count),
    .ripple_carry_out(link.ripple_carry_out));

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 chk("rdata", e, bus_rdata);
  endtask
  task automatic edge_chk(input logic [3:0] e);
    @(posedge clk);
    #1 chk("count", {28'h0, e}, {28'h0, link.count});
  endtask
  task automatic ld(input logic [3:0] v);
    wr(REG_PRESET, {28'h0, v});
    wr(REG_CMD, 32'h0000_0001);
    edge_chk(v);
  endtask
  task automatic tally_chk(input logic [1:0] m, input logic [15:0] ni,
                           input logic [15:0] nl, input logic [15:0] nc);
    chk("mode", {30'h0, m}, {30'h0, mode_seen});
    chk("incs", {16'h0, ni}, {16'h0, inc_total});
    chk("loads", {16'h0, nl}, {16'h0, load_total});
    chk("clears", {16'h0, nc}, {16'h0, clear_total});
  endtask
  task automatic rst4;
    srst <= 1'b1;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    #20000;
    errors++;
    final_report();
  end
  initial begin
    rst4();
    rd(REG_MODULUS, 32'h0000_000f);
    rd(REG_STATUS, 32'h0000_0300);
    rd(8'h20, 32'h0000_0000);
    $display("test reset done");
    for (i = 0; i < 16; i++) ld(i[3:0]);
    $display("test load done");
    ld(4'hc);
    wr(REG_CTRL, 32'h0000_0003);
    exp = 4'hc;
    for (i = 0; i < 6; i++) begin
      exp = exp + 4'h1;
      edge_chk(exp);
      chk("carry", {31'h0, exp == 4'hf}, {31'h0, carry_seen});
      chk("wrap", {31'h0, exp == 4'h0}, {31'h0, wrap_pulse});
      chk("mirror", {28'h0, exp}, {28'h0, count_mirror});
    end
    wr(REG_CTRL, 32'h0000_0002);
    edge_chk(4'h4);
    ld(4'hf);
    rd(REG_STATUS, 32'h0000_031f);
    wr(REG_CTRL, 32'h0000_0001);
    edge_chk(4'hf);
    chk("carry", 32'h0, {31'h0, link.ripple_carry_out});
    rd(REG_CARRIES, 32'h0000_0001);
    $display("test count done");
    wr(REG_PRESET, 32'h0000_0009);
    wr(REG_CMD, 32'h0000_0003);
    edge_chk(4'h0);
    ld(4'h9);
    wr(REG_CMD, 32'h0000_0002);
    edge_chk(4'h0);
    wr(REG_CTRL, 32'h0000_0003);
    wr(REG_PRESET, 32'h0000_0007);
    wr(REG_CMD, 32'h0000_0001);
    edge_chk(4'h7);
    edge_chk(4'h8);
    tally_chk(2'h1, 16'h000d, 16'h0014, 16'h0002);
    $display("test priority done");
    @(posedge clk);
    rst4();
    #1 chk("count", 32'h0, {28'h0, link.count});
    rd(REG_CTRL, 32'h0000_0000);
    $display("test midrun reset done");
    wr(REG_MODULUS, 32'h0000_0005);
    wr(REG_CTRL, 32'h0000_0007);
    exp = 4'h0;
    for (i = 0; i < 13; i++) begin
      exp = (exp == 4'h5) ? 4'h0 : exp + 4'h1;
      edge_chk(exp);
    end
    wr(REG_CTRL, 32'h0000_000b);
    edge_chk(4'h0);
    edge_chk(4'h0);
    tally_chk(2'h3, 16'h000d, 16'h0000, 16'h0004);
    rd(REG_CARRIES, 32'h0000_0000);
    $display("test modulus done");
    final_report();
  end
endmodule

`default_nettype wire
